// file: pls_pkg.sv
// package: register map, field layout and codes for the port led select block
package pls_pkg;

  // axi4-lite register byte offsets
  localparam logic [11:0] WAN_MISC_OFF   = 12'h000;
  localparam logic [11:0] SW_CTRL0_OFF   = 12'h004;
  localparam logic [11:0] BOOT_WIDTH_OFF = 12'h008;
  localparam logic [11:0] PORT_STAT_OFF  = 12'h00C;
  localparam int          ADDR_W         = 12;

  // field positions
  localparam int WAN_FIRST_LSB  = 0;
  localparam int WAN_SECOND_LSB = 4;
  localparam int LAN_FIRST_LSB  = 25;
  localparam int LAN_SECOND_LSB = 22;
  localparam int SEL_W          = 3;

  // reset values
  localparam logic [31:0] WAN_MISC_RST = 32'h0000_0000;
  localparam logic [31:0] SW_CTRL0_RST = 32'h0000_0000;

  // writable field masks
  localparam logic [31:0] WAN_MISC_MASK = 32'h0000_0077;
  localparam logic [31:0] SW_CTRL0_MASK = 32'h0FC0_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_SPEED    = 3'b000,
    SEL_LINK     = 3'b001,
    SEL_DUPLEX   = 3'b010,
    SEL_COLL     = 3'b011,
    SEL_ACT      = 3'b100,
    SEL_FDX_COLL = 3'b101,
    SEL_LINK_ACT = 3'b110,
    SEL_NONE     = 3'b111
  } pls_sel_t;

  typedef enum logic [1:0] {
    BW_RSVD = 2'b00,
    BW_8    = 2'b01,
    BW_16   = 2'b10,
    BW_32   = 2'b11
  } pls_bw_t;

  // per-port phy status
  typedef struct packed {
    logic speed100;
    logic link;
    logic full_dup;
    logic coll;
    logic act;
  } pls_phy_t;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } pls_wst_t;

  typedef struct packed {
    pls_wst_t    wst;
    logic        awr;
    logic [11:0] awaddr;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] wan_misc;
    logic [31:0] sw_ctrl0;
    logic [1:0]  bw_code;
    logic        strap_done;
    logic        wan_first;
    logic        wan_second;
    logic [3:0]  lan_first;
    logic [3:0]  lan_second;
    logic        wan_oe;
  } pls_state_t;

endpackage

// file: pls_led_sel.sv
// port led select block with boot width strap capture and axi4-lite registers
//
// Behaviour
// RULE_01 - led select 000 speed,001 link,010 duplex,011 coll,100 act,101 fdx coll,110 link/act
// RULE_02 - first wan led follows wan misc control bits 2..0
// RULE_03 - second wan led follows wan misc control bits 6..4
// RULE_04 - every lan first led uses shared switch control 0 bits 27..25
// RULE_05 - every lan second led uses shared switch control 0 bits 24..22
// RULE_06 - during reset wan led pins are inputs giving width code, first low
// RULE_07 - width code 01 8 bit, 10 16 bit, 11 32 bit, 00 reserved
// RULE_08 - select code 111 holds the led inactive
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

module pls_led_sel (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire pls_pkg::pls_phy_t wan_phy,
  input  wire pls_pkg::pls_phy_t lan_phy [4],
  input  wire logic              wan_led_first_in,
  input  wire logic              wan_led_second_in,
  output logic                   wan_led_first,
  output logic                   wan_led_second,
  output logic                   wan_led_oe,
  output logic [3:0]             lan_led_first,
  output logic [3:0]             lan_led_second,
  output logic [1:0]             boot_width_strap_code,
  output logic [5:0]             boot_bus_width
);

  pls_pkg::pls_state_t s_q;
  pls_pkg::pls_state_t s_d;

  // led indication decode; leds are active high here
  function automatic logic led_pick(input logic [2:0] sel, input pls_pkg::pls_phy_t p);
    logic r;
    r = 1'b0;
    case (sel)                                               // RULE_01
      pls_pkg::SEL_SPEED:    r = p.speed100;
      pls_pkg::SEL_LINK:     r = p.link;
      pls_pkg::SEL_DUPLEX:   r = p.full_dup;
      pls_pkg::SEL_COLL:     r = p.coll;
      pls_pkg::SEL_ACT:      r = p.act;
      pls_pkg::SEL_FDX_COLL: r = p.full_dup & p.coll;
      pls_pkg::SEL_LINK_ACT: r = p.link & ~p.act;            // lit on link, blinks off on traffic
      default:               r = 1'b0;                       // RULE_08
    endcase
    return r;
  endfunction

  logic [2:0] wan_sel_first;
  logic [2:0] wan_sel_second;
  logic [2:0] lan_sel_first;
  logic [2:0] lan_sel_second;
  logic [3:0] lan_first_d;
  logic [3:0] lan_second_d;

  assign wan_sel_first  = s_q.wan_misc[pls_pkg::WAN_FIRST_LSB +: pls_pkg::SEL_W];   // RULE_02
  assign wan_sel_second = s_q.wan_misc[pls_pkg::WAN_SECOND_LSB +: pls_pkg::SEL_W];  // RULE_03
  assign lan_sel_first  = s_q.sw_ctrl0[pls_pkg::LAN_FIRST_LSB +: pls_pkg::SEL_W];   // RULE_04
  assign lan_sel_second = s_q.sw_ctrl0[pls_pkg::LAN_SECOND_LSB +: pls_pkg::SEL_W];  // RULE_05

  // ****************************************
  // per-port lan led decode
  // ****************************************
  generate
    for (genvar i = 0; i < 4; i++) begin : g_lan
      assign lan_first_d[i]  = led_pick(lan_sel_first, lan_phy[i]);   // RULE_04
      assign lan_second_d[i] = led_pick(lan_sel_second, lan_phy[i]);  // RULE_05
    end
  endgenerate

  // ****************************************
  // register read mux
  // ****************************************
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      pls_pkg::WAN_MISC_OFF:   rd_word = s_q.wan_misc;
      pls_pkg::SW_CTRL0_OFF:   rd_word = s_q.sw_ctrl0;
      pls_pkg::BOOT_WIDTH_OFF: rd_word = {30'h0, s_q.bw_code};
      pls_pkg::PORT_STAT_OFF:  rd_word = {16'h0000, lan_second_d, lan_first_d,
                                          6'h00, s_q.wan_second, s_q.wan_first};
      default:                 rd_hit  = 1'b0;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r & mask;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (!s_q.strap_done) begin
      // first cycle after reset release: pins still hold the strap, latch it
      s_d.bw_code    = {wan_led_second_in, wan_led_first_in};   // RULE_06
      s_d.strap_done = 1'b1;
      s_d.wan_oe     = 1'b1;
    end
    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awr    = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wr    = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    case (s_q.wst)
      pls_pkg::WR_IDLE: begin
        if (s_q.awr && s_q.wr) begin
          s_d.awr    = 1'b0;
          s_d.wr     = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp  = pls_pkg::RESP_OKAY;
          s_d.wst    = pls_pkg::WR_RESP;
          case (s_q.awaddr)
            pls_pkg::WAN_MISC_OFF: s_d.wan_misc = merge(s_q.wan_misc, s_q.wdata, s_q.wstrb,
                                                        pls_pkg::WAN_MISC_MASK);
            pls_pkg::SW_CTRL0_OFF: s_d.sw_ctrl0 = merge(s_q.sw_ctrl0, s_q.wdata, s_q.wstrb,
                                                        pls_pkg::SW_CTRL0_MASK);
            pls_pkg::BOOT_WIDTH_OFF, pls_pkg::PORT_STAT_OFF: ;
            default:               s_d.bresp    = pls_pkg::RESP_SLVERR;
          endcase
        end
      end
      pls_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.wst    = pls_pkg::WR_IDLE;
        end
      end
      default: s_d.wst = pls_pkg::WR_IDLE;
    endcase
    if (s_q.rvalid) begin
      if (s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_hit ? pls_pkg::RESP_OKAY : pls_pkg::RESP_SLVERR;
    end
    s_d.wan_first  = led_pick(wan_sel_first, wan_phy);    // RULE_02
    s_d.wan_second = led_pick(wan_sel_second, wan_phy);   // RULE_03
    s_d.lan_first  = lan_first_d;
    s_d.lan_second = lan_second_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.wan_misc <= pls_pkg::WAN_MISC_RST;
      s_q.sw_ctrl0 <= pls_pkg::SW_CTRL0_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready  = ~s_q.awr;
  assign s_axi_wready   = ~s_q.wr;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = ~s_q.rvalid;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign wan_led_first  = s_q.wan_first;
  assign wan_led_second = s_q.wan_second;
  // pins stay inputs through reset and the strap cycle
  assign wan_led_oe     = s_q.wan_oe;                      // RULE_06
  assign lan_led_first  = s_q.lan_first;
  assign lan_led_second = s_q.lan_second;
  assign boot_width_strap_code = s_q.bw_code;

  logic [5:0] bw_dec;
  always_comb begin
    case (s_q.bw_code)                                     // RULE_07
      pls_pkg::BW_8:  bw_dec = 6'h08;
      pls_pkg::BW_16: bw_dec = 6'h10;
      pls_pkg::BW_32: bw_dec = 6'h20;
      default:        bw_dec = 6'h00;
    endcase
  end
  logic [5:0] bw_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bw_q <= 6'h00;
    end else begin
      bw_q <= bw_dec;
    end
  end
  assign boot_bus_width = bw_q;

  // ****************************************
  // assertions
  // ****************************************
  // strap window: pins released and sampled once, then driven
  sequence s_strap_window;
    !s_q.strap_done && !wan_led_oe ##1 s_q.strap_done;
  endsequence

  // both write halves taken at one edge with no answer pending
  sequence s_wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence

  // led selection checks
  a_wan_first_sel: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_02
    ($past(wan_sel_first) == pls_pkg::SEL_LINK && s_q.strap_done)
      |-> wan_led_first == $past(wan_phy.link))
    else $error("wan first led does not follow link");
  a_wan_second_sel: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_03
    ($past(wan_sel_second) == pls_pkg::SEL_SPEED && s_q.strap_done)
      |-> wan_led_second == $past(wan_phy.speed100))
    else $error("wan second led does not follow speed");
  a_lan_first_coll: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_04
    ($past(lan_sel_first) == pls_pkg::SEL_COLL && s_q.strap_done)
      |-> lan_led_first[2] == $past(lan_phy[2].coll))
    else $error("lan first led does not follow collision");
  a_lan_second_act: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_05
    ($past(lan_sel_second) == pls_pkg::SEL_ACT && s_q.strap_done)
      |-> lan_led_second[0] == $past(lan_phy[0].act))
    else $error("lan second led does not follow activity");
  a_fdx_coll: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_01
    ($past(wan_sel_first) == pls_pkg::SEL_FDX_COLL && s_q.strap_done
      && !$past(wan_phy.full_dup))
      |-> !wan_led_first)
    else $error("fdx collision lit without full duplex");
  a_link_act: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_01
    ($past(wan_sel_first) == pls_pkg::SEL_LINK_ACT && s_q.strap_done)
      |-> wan_led_first == ($past(wan_phy.link) && !$past(wan_phy.act)))
    else $error("link activity led wrong");
  a_sel_none_off: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_08
    ($past(lan_sel_first) == pls_pkg::SEL_NONE && s_q.strap_done)
      |-> lan_led_first == 4'h0)
    else $error("unused select code lit an led");
  a_lan_second_none: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_08
    ($past(lan_sel_second) == pls_pkg::SEL_NONE && s_q.strap_done)
      |-> lan_led_second == 4'h0)
    else $error("unused select code lit a second led");

  // strap and boot width checks
  a_strap_capture: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_06
    s_strap_window
      |-> boot_width_strap_code == {$past(wan_led_second_in), $past(wan_led_first_in)})
    else $error("strap not captured from led pins");
  a_oe_strap: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_06
    wan_led_oe == s_q.strap_done)
    else $error("wan led pins driven inside the strap window");
  a_bw_decode: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE_07
    s_q.bw_code == pls_pkg::BW_16 ##1 s_q.bw_code == pls_pkg::BW_16
      |-> boot_bus_width == 6'h10)
    else $error("boot width decode wrong");

  // register bus checks
  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_pair |-> ##2 s_axi_bvalid)
    else $error("write response not given two cycles after the request");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not given one cycle after the request");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before it was taken");

endmodule

// file: pls_strap_model.sv
// board model: boot width strap pulls and the two wan led pins
`timescale 1ns/1ps
module pls_strap_model (
  input  wire logic [1:0] strap_code,
  input  wire logic       drv_first,
  input  wire logic       drv_second,
  input  wire logic       oe,
  output logic            pin_first,
  output logic            pin_second
);
  // pulls set the level only while the device releases the pins
  assign pin_first  = oe ? drv_first : strap_code[0];
  assign pin_second = oe ? drv_second : strap_code[1];
endmodule

// file: pls_led_sel_tb.sv
// self-checking testbench for the port led select block
`timescale 1ns/1ps
module pls_led_sel_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, oe, pin_f, pin_s, led_f, led_s;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, lan_f, lan_s;
  logic [1:0]  bresp, rresp, strap, code;
  logic [5:0]  width;
  pls_pkg::pls_phy_t wan_phy;
  pls_pkg::pls_phy_t lan_phy [4];
  int n_fail, cmp_count, cyc;

  pls_led_sel pls_led_sel_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wan_phy(wan_phy), .lan_phy(lan_phy), .wan_led_first_in(pin_f),
    .wan_led_second_in(pin_s), .wan_led_first(led_f), .wan_led_second(led_s),
    .wan_led_oe(oe), .lan_led_first(lan_f), .lan_led_second(lan_s),
    .boot_width_strap_code(code), .boot_bus_width(width));

  pls_strap_model pls_strap_model_inst (.strap_code(strap), .drv_first(led_f),
    .drv_second(led_s), .oe(oe), .pin_first(pin_f), .pin_second(pin_s));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ****************
  // helpers
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic exp_led(input logic [2:0] s, input pls_pkg::pls_phy_t p);
    case (s)
      3'h0: return p.speed100;
      3'h1: return p.link;
      3'h2: return p.full_dup;
      3'h3: return p.coll;
      3'h4: return p.act;
      3'h5: return p.full_dup & p.coll;
      3'h6: return p.link & ~p.act;
      default: return 1'b0;
    endcase
  endfunction

  // ready is registered, so the negedge view decides the next rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      if (hr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_strap(input logic [1:0] c);
    logic [5:0] w;
    w = (c == 2'h1) ? 6'h08 : (c == 2'h2) ? 6'h10 : (c == 2'h3) ? 6'h20 : 6'h00;
    @(posedge aclk);
    strap <= c;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("oe in reset", 32'h0, {31'h0, oe});
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("oe after strap", 32'h1, {31'h0, oe});
    chk("strap code", {30'h0, c}, {30'h0, code});
    chk("boot width", {26'h0, w}, {26'h0, width});
  endtask

  task automatic t_wan();
    logic [1:0] r;
    for (int s = 0; s < 8; s++) begin
      axi_wr(pls_pkg::WAN_MISC_OFF, {25'h0, 3'(7 - s), 1'b0, 3'(s)}, r);
      chk("wan wr resp", {30'h0, pls_pkg::RESP_OKAY}, {30'h0, r});
      for (int v = 0; v < 32; v++) begin
        @(posedge aclk);
        wan_phy <= 5'(v);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("wan first", {31'h0, exp_led(3'(s), 5'(v))}, {31'h0, led_f});
        chk("wan second", {31'h0, exp_led(3'(7 - s), 5'(v))}, {31'h0, led_s});
        chk("wan pin", {31'h0, led_f}, {31'h0, pin_f});
      end
    end
  endtask

  task automatic t_lan();
    logic [1:0] r;
    logic [3:0] ef, es;
    for (int s = 0; s < 8; s++) begin
      axi_wr(pls_pkg::SW_CTRL0_OFF, {4'hF, 3'(s), 3'(7 - s), 22'h3FFFFF}, r);
      for (int v = 0; v < 32; v++) begin
        @(posedge aclk);
        for (int i = 0; i < 4; i++) lan_phy[i] <= 5'(v + 7 * i);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        for (int i = 0; i < 4; i++) begin
          ef[i] = exp_led(3'(s), 5'(v + 7 * i));
          es[i] = exp_led(3'(7 - s), 5'(v + 7 * i));
        end
        chk("lan first", {28'h0, ef}, {28'h0, lan_f});
        chk("lan second", {28'h0, es}, {28'h0, lan_s});
      end
    end
  endtask

  task automatic t_regs();
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(12'h010, 32'hFFFF_FFFF, r);
    chk("unmapped wr resp", {30'h0, pls_pkg::RESP_SLVERR}, {30'h0, r});
    axi_rd(12'h010, d, r);
    chk("unmapped rd resp", {30'h0, pls_pkg::RESP_SLVERR}, {30'h0, r});
    wstrb <= 4'hE;
    axi_wr(pls_pkg::WAN_MISC_OFF, 32'hFFFF_FF70, r);
    wstrb <= 4'hF;
    axi_rd(pls_pkg::WAN_MISC_OFF, d, r);
    chk("wan misc rd", 32'h0000_0007, d);
    axi_rd(pls_pkg::SW_CTRL0_OFF, d, r);
    chk("sw ctrl0 rd", 32'h0E00_0000, d);
    axi_rd(pls_pkg::PORT_STAT_OFF, d, r);
    chk("led status rd", 32'h0000_9002, d);
    axi_wr(pls_pkg::BOOT_WIDTH_OFF, 32'hFFFF_FFFF, r);
    chk("ro wr resp", {30'h0, pls_pkg::RESP_OKAY}, {30'h0, r});
    axi_rd(pls_pkg::BOOT_WIDTH_OFF, d, r);
    chk("boot width rd", 32'h0000_0002, d);
  endtask

  initial begin
    aresetn = 1'b0;
    strap = 2'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wan_phy = 5'h00;
    for (int i = 0; i < 4; i++) lan_phy[i] = 5'h00;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    for (int c = 0; c < 4; c++) t_strap(2'(c));
    t_strap(2'h2);
    t_wan();
    t_lan();
    t_regs();
    complete_run();
  end
endmodule
